// *** dv/tb_top.sv ***
// Self-checking bench of the timer mode, clock select and capture control block.
// Assumes tmcc_top, tmcc_pins and the shared defines header on the include path.
`default_nettype none
`include "tmcc_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tmcc_pkg::*;
  logic       clk;
  logic       rst_n;
  tmcc_byte_t addr;
  tmcc_byte_t wdata;
  tmcc_byte_t rdata;
  logic       wr;
  logic       rd;
  logic       cap_level;
  logic       ext_park;
  logic       ext_go;
  logic [7:0] ext_n;
  logic [7:0] ext_half;
  logic       capture_pin;
  logic       ext_clk_pin;
  logic       ext_busy;
  logic       comp_a;
  logic       comp_b;
  logic       irq;
  int         err_count;
  int         samples_checked;
  int         cycles;
  tmcc_byte_t rv;
  tmcc_byte_t rv2;
  tmcc_top dut_u (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CAPTURE_PIN(capture_pin), .EXT_CLK_PIN(ext_clk_pin),
    .COMPARE_A_OUT(comp_a), .COMPARE_B_OUT(comp_b), .IRQ(irq));
  tmcc_pins pins_u (.clk(clk), .rst_n(rst_n), .cap_level(cap_level), .ext_park(ext_park),
    .ext_go(ext_go), .ext_n(ext_n), .ext_half(ext_half), .capture_pin(capture_pin),
    .ext_clk_pin(ext_clk_pin), .ext_busy(ext_busy));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input tmcc_byte_t seen, input tmcc_byte_t exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input tmcc_byte_t a, input tmcc_byte_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input tmcc_byte_t a, output tmcc_byte_t d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input tmcc_byte_t a, input tmcc_byte_t exp);
    tmcc_byte_t v;
    rd_reg(a, v);
    chk(v, exp);
  endtask
  task automatic flag_chk(input tmcc_byte_t m, input tmcc_byte_t exp);
    rd_reg(`TMCC_OFS_STATUS, rv);
    chk(rv & m, exp);
    wr_reg(`TMCC_OFS_STATUS, 8'hFF);
  endtask
  task automatic cnt_set(input tmcc_word_t w);
    wr_reg(`TMCC_OFS_CNT_H, w[15:8]);
    wr_reg(`TMCC_OFS_CNT_L, w[7:0]);
  endtask
  task automatic pins(input logic c, input logic p);
    @(posedge clk);
    cap_level <= c;
    ext_park  <= p;
    idle(10);
  endtask
  task automatic pulse(input int n);
    @(posedge clk);
    cap_level <= 1'b1;
    repeat (n) @(posedge clk);
    cap_level <= 1'b0;
    idle(10);
  endtask
  task automatic burst(input logic [7:0] n, input logic [7:0] h);
    int guard;
    guard = 0;
    @(posedge clk);
    ext_n    <= n;
    ext_half <= h;
    ext_go   <= 1'b1;
    @(posedge clk);
    ext_go <= 1'b0;
    idle(1);
    while (ext_busy !== 1'b0 && guard < 3000)
    begin
      @(posedge clk);
      guard++;
    end
    chk({7'h00, guard < 3000}, 8'h01);
    idle(6);
  endtask
  task automatic t_regs();
    rd_chk(`TMCC_OFS_CTRL_B, 8'h00);
    rd_chk(`TMCC_OFS_STATUS, 8'h00);
    wr_reg(`TMCC_OFS_CTRL_B, 8'hFF);
    wr_reg(8'h80, 8'hFF);
    rd_chk(`TMCC_OFS_CTRL_B, 8'hDF);
    rd_chk(8'h80, 8'h00);
    wr_reg(`TMCC_OFS_CTRL_B, 8'h00);
  endtask
  task automatic t_prescale();
    int divs[6] = '{0, 1, 8, 64, 256, 1024};
    int win;
    for (int cs = 0; cs < 6; cs++)
    begin
      win = (cs == 0) ? 64 : 4 * divs[cs];
      wr_reg(`TMCC_OFS_CTRL_B, 8'(cs));
      rd_reg(`TMCC_OFS_CNT_L, rv);
      idle(win - 2);
      rd_reg(`TMCC_OFS_CNT_L, rv2);
      chk(rv2 - rv, (cs == 0) ? 8'h00 : 8'h04);
    end
  endtask
  task automatic t_ext();
    wr_reg(`TMCC_OFS_CTRL_B, 8'h07);
    cnt_set(16'h0000);
    burst(8'h05, 8'h03);
    rd_chk(`TMCC_OFS_CNT_L, 8'h05);
    pins(1'b0, 1'b1);
    rd_chk(`TMCC_OFS_CNT_L, 8'h06);
    pins(1'b0, 1'b0);
    rd_chk(`TMCC_OFS_CNT_L, 8'h06);
    wr_reg(`TMCC_OFS_CTRL_B, 8'h06);
    cnt_set(16'h0000);
    burst(8'h03, 8'h09);
    pins(1'b0, 1'b1);
    rd_chk(`TMCC_OFS_CNT_L, 8'h03);
    pins(1'b0, 1'b0);
    rd_chk(`TMCC_OFS_CNT_L, 8'h04);
  endtask
  task automatic t_ovf();
    wr_reg(`TMCC_OFS_CTRL_B, 8'h00);
    cnt_set(16'hFFFE);
    wr_reg(`TMCC_OFS_STATUS, 8'hFF);
    wr_reg(`TMCC_OFS_CTRL_B, 8'h01);
    wr_reg(`TMCC_OFS_CTRL_B, 8'h00);
    rd_reg(`TMCC_OFS_STATUS, rv);
    chk(rv & 8'h01, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr_reg(`TMCC_OFS_MASK, 8'h01);
    rd_reg(`TMCC_OFS_MASK, rv);
    chk({7'h00, irq}, 8'h01);
    flag_chk(8'h01, 8'h01);
    rd_reg(`TMCC_OFS_STATUS, rv);
    chk({7'h00, irq}, 8'h00);
    wr_reg(`TMCC_OFS_MASK, 8'h00);
    wr_reg(`TMCC_OFS_CMPA_H, 8'h00);
    wr_reg(`TMCC_OFS_CMPA_L, 8'h10);
    wr_reg(`TMCC_OFS_CTRL_B, 8'h08);
    cnt_set(16'h000E);
    wr_reg(`TMCC_OFS_STATUS, 8'hFF);
    wr_reg(`TMCC_OFS_CTRL_B, 8'h09);
    idle(30);
    wr_reg(`TMCC_OFS_CTRL_B, 8'h08);
    flag_chk(8'h03, 8'h02);
    rd_reg(`TMCC_OFS_CNT_L, rv);
    chk({7'h00, rv <= 8'h10}, 8'h01);
    wr_reg(`TMCC_OFS_CTRL_A, 8'h01);
    wr_reg(`TMCC_OFS_CTRL_B, 8'h19);
    cnt_set(16'h0055);
    idle(10);
    rd_chk(`TMCC_OFS_CNT_L, 8'h55);
  endtask
  task automatic t_pwm();
    tmcc_byte_t tops[3] = '{8'h00, 8'h01, 8'h03};
    int idx;
    for (int m = 1; m < 8; m++)
    begin
      idx = (m & 3) - 1;
      if (m == 4)
        continue;
      wr_reg(`TMCC_OFS_CTRL_A, 8'h00);
      wr_reg(`TMCC_OFS_CTRL_B, 8'((m & 12) << 1));
      wr_reg(`TMCC_OFS_CTRL_A, 8'(m & 3));
      cnt_set({tops[idx], 8'hFE});
      wr_reg(`TMCC_OFS_STATUS, 8'hFF);
      wr_reg(`TMCC_OFS_CTRL_B, 8'((m & 12) << 1) | 8'h01);
      wr_reg(`TMCC_OFS_CTRL_B, 8'((m & 12) << 1));
      flag_chk(8'h01, (m > 4) ? 8'h01 : 8'h00);
      rd_chk(`TMCC_OFS_CNT_H, (m > 4) ? 8'h00 : tops[idx]);
      rd_chk(`TMCC_OFS_CNT_L, (m > 4) ? 8'h00 : 8'hFE);
    end
  endtask
  task automatic t_capture();
    wr_reg(`TMCC_OFS_CTRL_A, 8'h00);
    wr_reg(`TMCC_OFS_CTRL_B, 8'h40);
    cnt_set(16'h1234);
    wr_reg(`TMCC_OFS_STATUS, 8'hFF);
    wr_reg(`TMCC_OFS_MASK, 8'h08);
    pins(1'b1, 1'b0);
    chk({7'h00, irq}, 8'h01);
    rd_chk(`TMCC_OFS_CAP_L, 8'h34);
    rd_chk(`TMCC_OFS_CAP_H, 8'h12);
    flag_chk(8'h08, 8'h08);
    pins(1'b0, 1'b0);
    flag_chk(8'h08, 8'h00);
    wr_reg(`TMCC_OFS_CTRL_B, 8'h00);
    cnt_set(16'h5678);
    pins(1'b1, 1'b0);
    flag_chk(8'h08, 8'h00);
    pins(1'b0, 1'b0);
    rd_chk(`TMCC_OFS_CAP_H, 8'h56);
    flag_chk(8'h08, 8'h08);
    wr_reg(`TMCC_OFS_MASK, 8'h00);
  endtask
  task automatic filt_cap(input tmcc_byte_t ctrl, output tmcc_byte_t v);
    wr_reg(`TMCC_OFS_CTRL_B, 8'h00);
    cnt_set(16'h0000);
    wr_reg(`TMCC_OFS_CTRL_B, ctrl);
    cap_level <= 1'b1;
    idle(12);
    pins(1'b0, 1'b0);
    rd_reg(`TMCC_OFS_CAP_L, v);
    wr_reg(`TMCC_OFS_CTRL_B, 8'h00);
  endtask
  task automatic t_filter();
    filt_cap(8'h41, rv);
    filt_cap(8'hC1, rv2);
    chk(rv2 - rv, 8'h04);
    wr_reg(`TMCC_OFS_CTRL_B, 8'hC0);
    wr_reg(`TMCC_OFS_STATUS, 8'hFF);
    pulse(3);
    flag_chk(8'h08, 8'h00);
    pulse(4);
    flag_chk(8'h08, 8'h08);
  endtask
  task automatic t_block();
    int modes[5] = '{8, 10, 12, 14, 9};
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(`TMCC_OFS_CTRL_A, 8'(modes[i] & 3));
      wr_reg(`TMCC_OFS_CTRL_B, 8'h40 | 8'((modes[i] & 12) << 1));
      wr_reg(`TMCC_OFS_STATUS, 8'hFF);
      pins(1'b1, 1'b0);
      pins(1'b0, 1'b0);
      flag_chk(8'h08, (i == 4) ? 8'h08 : 8'h00);
    end
  endtask
  task automatic t_com();
    wr_reg(`TMCC_OFS_CTRL_B, 8'h00);
    wr_reg(`TMCC_OFS_CTRL_A, 8'hB1);
    wr_reg(`TMCC_OFS_CMPA_L, 8'h80);
    wr_reg(`TMCC_OFS_CMPB_L, 8'h60);
    cnt_set(16'h00F0);
    wr_reg(`TMCC_OFS_CTRL_B, 8'h01);
    idle(200);
    chk({7'h00, comp_a}, 8'h01);
    chk({7'h00, comp_b}, 8'h00);
    idle(250);
    chk({7'h00, comp_a}, 8'h00);
    chk({7'h00, comp_b}, 8'h01);
  endtask
  initial
  begin
    rst_n     = 1'b0;
    addr      = 8'h00;
    wdata     = 8'h00;
    wr        = 1'b0;
    rd        = 1'b0;
    cap_level = 1'b0;
    ext_park  = 1'b0;
    ext_go    = 1'b0;
    ext_n     = 8'h00;
    ext_half  = 8'h01;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_prescale();
    t_ext();
    t_ovf();
    t_pwm();
    t_capture();
    t_filter();
    t_block();
    t_com();
    stop_test();
  end
endmodule
`default_nettype wire

// *** dv/tmcc_pins.sv ***
// Pin model of the outside world: the capture input and the external count clock.
// Assumes the bench changes its requests just after a rising edge of clk.
`default_nettype none
module tmcc_pins (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       cap_level,
  input  wire logic       ext_park,
  input  wire logic       ext_go,
  input  wire logic [7:0] ext_n,
  input  wire logic [7:0] ext_half,
  output logic            capture_pin,
  output logic            ext_clk_pin,
  output logic            ext_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] edges_left;
  logic [7:0] wait_cnt;
  logic       toggled;
  // Between bursts the clock pin rests at the parked level.
  assign ext_clk_pin = ext_park ^ toggled;
  assign ext_busy    = (edges_left != 9'h000);
  always_ff @(posedge clk)
  begin
    capture_pin <= cap_level;
    if (!rst_n)
    begin
      edges_left <= 9'h000;
      wait_cnt   <= 8'h00;
      toggled    <= 1'b0;
    end
    else if (ext_go && !ext_busy)
    begin
      edges_left <= {ext_n, 1'b0};
      wait_cnt   <= ext_half;
    end
    else if (ext_busy && wait_cnt == 8'h01)
    begin
      toggled    <= !toggled;
      edges_left <= edges_left - 9'h001;
      wait_cnt   <= ext_half;
    end
    else if (ext_busy)
    begin
      wait_cnt <= wait_cnt - 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** hdl/tmcc_capture.sv ***
// Capture pin synchroniser, optional noise filter and edge selection.
// Assumes the pin is asynchronous to clk; disable_cap comes from clk logic.
`default_nettype none
`include "tmcc_defines.svh"
module tmcc_capture (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic filter_en,
  input  wire logic rising_sel,
  input  wire logic disable_cap,
  output logic      event_pulse
);
  logic                         sync1;
  logic                         sync2;
  logic [`TMCC_FILTER_HIST-1:0] hist;
  logic                         filt;
  logic                         prev;
  wire                          all_same;
  wire                          sel_level;
  wire                          edge_seen;

  assign all_same  = (hist == {`TMCC_FILTER_HIST{sync2}});
  assign sel_level = filter_en ? filt : sync2;
  assign edge_seen = rising_sel ? (sel_level && !prev) : (!sel_level && prev);
  assign event_pulse = edge_seen && !disable_cap;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      hist  <= '0;
      filt  <= 1'b0;
      prev  <= 1'b0;
    end
    else
    begin
      sync1 <= pin;
      sync2 <= sync1;
      hist  <= {hist[`TMCC_FILTER_HIST-2:0], sync2};
      if (all_same)
      begin
        filt <= sync2;
      end
      prev <= sel_level;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  filter_hold_a: assert property ($changed(filt) |-> $past(all_same))
    else $error("Filter output changed without four equal samples.");
  filter_delay_a: assert property (filter_en && $changed(sync2) ##1 $stable(sync2)[*3] ##1
    filter_en |-> filt == $past(sync2))
    else $error("Filtered capture level not settled four cycles after a change.");
  edge_sense_a: assert property (event_pulse |-> sel_level == rising_sel)
    else $error("Capture event on the wrong edge.");
  cap_block_a: assert property (disable_cap |-> !event_pulse)
    else $error("Capture event while the pin is disconnected.");
  cover property (filter_en && event_pulse);
endmodule
`default_nettype wire

// *** hdl/tmcc_defines.svh ***
// Register offsets, field positions, reset values and counts of the timer
// mode, clock select and capture control block.
// Assumes inclusion by its bare name from the design files.
`ifndef TMCC_DEFINES_SVH
`define TMCC_DEFINES_SVH

`define TMCC_OFS_CTRL_A    8'h90
`define TMCC_OFS_CTRL_B    8'h91
`define TMCC_OFS_CNT_L     8'h94
`define TMCC_OFS_CNT_H     8'h95
`define TMCC_OFS_CAP_L     8'h96
`define TMCC_OFS_CAP_H     8'h97
`define TMCC_OFS_CMPA_L    8'h98
`define TMCC_OFS_CMPA_H    8'h99
`define TMCC_OFS_CMPB_L    8'h9A
`define TMCC_OFS_CMPB_H    8'h9B
`define TMCC_OFS_STATUS    8'h9C
`define TMCC_OFS_MASK      8'h9D

`define TMCC_A_COMA        6
`define TMCC_A_COMB        4
`define TMCC_A_WGMLO       0
`define TMCC_B_NOISE       7
`define TMCC_B_EDGE        6
`define TMCC_B_WGMHI       3
`define TMCC_B_CS          0
`define TMCC_CTRL_A_WMASK  8'hF3
`define TMCC_CTRL_B_WMASK  8'hDF

`define TMCC_ST_OVF        0
`define TMCC_ST_CMPA       1
`define TMCC_ST_CMPB       2
`define TMCC_ST_CAP        3

`define TMCC_RST_BYTE      8'h00
`define TMCC_RST_WORD      16'h0000
`define TMCC_RST_PRESC     10'h000

`define TMCC_TOP_MAX       16'hFFFF
`define TMCC_TOP_8BIT      16'h00FF
`define TMCC_TOP_9BIT      16'h01FF
`define TMCC_TOP_10BIT     16'h03FF

`define TMCC_DIV8_MASK     10'h007
`define TMCC_DIV64_MASK    10'h03F
`define TMCC_DIV256_MASK   10'h0FF
`define TMCC_DIV1024_MASK  10'h3FF

`define TMCC_FILTER_HIST   3

`endif

// *** hdl/tmcc_pkg.sv ***
// Types shared by the timer mode, clock select and capture control block.
// Assumes nothing of its surroundings.
`default_nettype none
package tmcc_pkg;
  typedef logic [7:0]  tmcc_byte_t;
  typedef logic [15:0] tmcc_word_t;
  typedef enum logic [2:0] {TMCC_NORMAL, TMCC_CTC, TMCC_FAST, TMCC_PHASE, TMCC_PFC,
                            TMCC_RSVD} tmcc_kind_t;
  typedef enum logic [2:0] {TMCC_CS_STOP, TMCC_CS_DIV1, TMCC_CS_DIV8, TMCC_CS_DIV64,
                            TMCC_CS_DIV256, TMCC_CS_DIV1024, TMCC_CS_EXT_FALL,
                            TMCC_CS_EXT_RISE} tmcc_clksel_t;
endpackage
`default_nettype wire

// *** hdl/tmcc_top.sv ***
// Mode, clock select and capture control of a 16-bit timer/counter.
// Assumes a single-cycle byte register port and asynchronous pins.
`default_nettype none
`include "tmcc_defines.svh"
module tmcc_top (
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  input  wire tmcc_pkg::tmcc_byte_t ADDR,
  input  wire tmcc_pkg::tmcc_byte_t WDATA,
  input  wire logic                 WR,
  input  wire logic                 RD,
  output tmcc_pkg::tmcc_byte_t      RDATA,
  input  wire logic                 CAPTURE_PIN,
  input  wire logic                 EXT_CLK_PIN,
  output logic                      COMPARE_A_OUT,
  output logic                      COMPARE_B_OUT,
  output logic                      IRQ
);
  import tmcc_pkg::*;

  function automatic tmcc_kind_t mode_kind(input logic [3:0] m);
    tmcc_kind_t k;
    k = TMCC_RSVD;
    unique case (m)
      4'h0:                      k = TMCC_NORMAL;
      4'h4, 4'hC:                k = TMCC_CTC;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: k = TMCC_FAST;
      4'h1, 4'h2, 4'h3, 4'hA, 4'hB: k = TMCC_PHASE;
      4'h8, 4'h9:                k = TMCC_PFC;
      4'hD:                      k = TMCC_RSVD;
    endcase
    return k;
  endfunction

  function automatic tmcc_word_t mode_top(input logic [3:0] m, input tmcc_word_t a,
                                          input tmcc_word_t c);
    tmcc_word_t t;
    t = `TMCC_TOP_MAX;
    unique case (m)
      4'h0, 4'hD:                t = `TMCC_TOP_MAX;
      4'h1, 4'h5:                t = `TMCC_TOP_8BIT;
      4'h2, 4'h6:                t = `TMCC_TOP_9BIT;
      4'h3, 4'h7:                t = `TMCC_TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF:    t = a;
      4'h8, 4'hA, 4'hC, 4'hE:    t = c;
    endcase
    return t;
  endfunction

  function automatic logic div_hit(input logic [9:0] p, input logic [9:0] m);
    return (p & m) == m;
  endfunction

  function automatic logic oc_next(input logic cur, input logic [1:0] com,
                                   input tmcc_kind_t k, input logic tog_ok,
                                   input logic match, input logic up_now,
                                   input logic bottom);
    logic r;
    r = cur;
    if (com == 2'h0)
      r = cur;
    else if (k == TMCC_NORMAL || k == TMCC_CTC)
      r = match ? ((com == 2'h1) ? !cur : com[0]) : cur;
    else if (com == 2'h1)
      r = (tog_ok && match) ? !cur : cur;
    else if (k == TMCC_FAST)
      r = bottom ? !com[0] : (match ? com[0] : cur);
    else if (match)
      r = up_now ? com[0] : !com[0];
    return r;
  endfunction

  tmcc_byte_t   ctrl_a;
  tmcc_byte_t   ctrl_b;
  tmcc_byte_t   status;
  tmcc_byte_t   mask;
  tmcc_word_t   cnt;
  tmcc_word_t   capture_value;
  tmcc_word_t   cmpa_buf;
  tmcc_word_t   cmpa;
  tmcc_word_t   cmpb_buf;
  tmcc_word_t   cmpb;
  logic         up;
  logic [9:0]   presc;
  logic         ext_s1;
  logic         ext_s2;
  logic         ext_s3;

  wire [3:0]    wave_mode;
  tmcc_kind_t   kind;
  tmcc_clksel_t cs;
  tmcc_word_t   top;
  wire          dual;
  wire          clk_tick;
  wire          tick;
  wire          ext_fall;
  wire          ext_rise;
  wire          cap_is_top;
  wire          cap_evt;
  wire          ge_top;
  wire          wrap;
  wire          turn_top;
  wire          turn_bot;
  wire          inc;
  tmcc_word_t   next_cnt;
  wire          ovf_evt;
  wire          reload;
  wire          match_a;
  wire          match_b;
  wire          tog_a;
  wire          cnt_write;
  wire          wr_hit_status;
  tmcc_byte_t   events;
  tmcc_byte_t   next_status;
  tmcc_byte_t   read_value;

  assign wave_mode = {ctrl_b[`TMCC_B_WGMHI+1:`TMCC_B_WGMHI],
                      ctrl_a[`TMCC_A_WGMLO+1:`TMCC_A_WGMLO]};
  assign kind = mode_kind(wave_mode);
  assign top  = mode_top(wave_mode, cmpa, capture_value);
  assign cs   = tmcc_clksel_t'(ctrl_b[`TMCC_B_CS+2:`TMCC_B_CS]);
  assign dual = (kind == TMCC_PHASE) || (kind == TMCC_PFC);

  assign ext_fall = ext_s3 && !ext_s2;
  assign ext_rise = ext_s2 && !ext_s3;
  assign clk_tick = (cs == TMCC_CS_DIV1) ||
                    (cs == TMCC_CS_DIV8 && div_hit(presc, `TMCC_DIV8_MASK)) ||
                    (cs == TMCC_CS_DIV64 && div_hit(presc, `TMCC_DIV64_MASK)) ||
                    (cs == TMCC_CS_DIV256 && div_hit(presc, `TMCC_DIV256_MASK)) ||
                    (cs == TMCC_CS_DIV1024 && div_hit(presc, `TMCC_DIV1024_MASK)) ||
                    (cs == TMCC_CS_EXT_FALL && ext_fall) ||
                    (cs == TMCC_CS_EXT_RISE && ext_rise);
  assign tick = clk_tick && (kind != TMCC_RSVD);

  assign ge_top   = cnt >= top;
  assign wrap     = tick && !dual && (cnt == top);
  assign turn_top = tick && dual && up && ge_top;
  assign turn_bot = tick && dual && !up && (cnt == `TMCC_RST_WORD);
  assign inc      = up ? !ge_top : (cnt == `TMCC_RST_WORD);
  assign next_cnt = !dual ? ((cnt == top) ? `TMCC_RST_WORD : cnt + 16'h0001)
                          : (inc ? cnt + 16'h0001 : cnt - 16'h0001);

  assign ovf_evt = ((kind == TMCC_NORMAL || kind == TMCC_CTC) && tick &&
                    cnt == `TMCC_TOP_MAX) ||
                   (kind == TMCC_FAST && wrap) || turn_bot;
  assign reload  = (kind == TMCC_NORMAL) || (kind == TMCC_CTC) ||
                   (kind == TMCC_FAST && wrap) || (kind == TMCC_PFC && turn_bot) ||
                   (kind == TMCC_PHASE && turn_top);
  assign match_a = tick && (cnt == cmpa);
  assign match_b = tick && (cnt == cmpb);
  assign tog_a   = (wave_mode == 4'hF) || (wave_mode == 4'h9) || (wave_mode == 4'hB);
  assign cap_is_top = wave_mode[3] && !wave_mode[0];

  assign cnt_write     = WR && (ADDR == `TMCC_OFS_CNT_L || ADDR == `TMCC_OFS_CNT_H);
  assign wr_hit_status = WR && (ADDR == `TMCC_OFS_STATUS);
  assign events = {4'h0, cap_evt, match_b, match_a, ovf_evt};
  assign next_status = (status & ~(wr_hit_status ? WDATA : `TMCC_RST_BYTE)) | events;

  assign read_value =
    (ADDR == `TMCC_OFS_CTRL_A) ? ctrl_a :
    (ADDR == `TMCC_OFS_CTRL_B) ? ctrl_b :
    (ADDR == `TMCC_OFS_CNT_L)  ? cnt[7:0] :
    (ADDR == `TMCC_OFS_CNT_H)  ? cnt[15:8] :
    (ADDR == `TMCC_OFS_CAP_L)  ? capture_value[7:0] :
    (ADDR == `TMCC_OFS_CAP_H)  ? capture_value[15:8] :
    (ADDR == `TMCC_OFS_CMPA_L) ? cmpa_buf[7:0] :
    (ADDR == `TMCC_OFS_CMPA_H) ? cmpa_buf[15:8] :
    (ADDR == `TMCC_OFS_CMPB_L) ? cmpb_buf[7:0] :
    (ADDR == `TMCC_OFS_CMPB_H) ? cmpb_buf[15:8] :
    (ADDR == `TMCC_OFS_STATUS) ? status :
    (ADDR == `TMCC_OFS_MASK)   ? mask : `TMCC_RST_BYTE;

  tmcc_capture u_capture (
    .clk         (CLK),
    .rst_n       (RST_N),
    .pin         (CAPTURE_PIN),
    .filter_en   (ctrl_b[`TMCC_B_NOISE]),
    .rising_sel  (ctrl_b[`TMCC_B_EDGE]),
    .disable_cap (cap_is_top),
    .event_pulse (cap_evt)
  );

  // Configuration and software-visible data registers.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      ctrl_a   <= `TMCC_RST_BYTE;
      ctrl_b   <= `TMCC_RST_BYTE;
      mask     <= `TMCC_RST_BYTE;
      cmpa_buf <= `TMCC_RST_WORD;
      cmpb_buf <= `TMCC_RST_WORD;
    end
    else if (WR)
    begin
      if (ADDR == `TMCC_OFS_CTRL_A) ctrl_a <= WDATA & `TMCC_CTRL_A_WMASK;
      if (ADDR == `TMCC_OFS_CTRL_B) ctrl_b <= WDATA & `TMCC_CTRL_B_WMASK;
      if (ADDR == `TMCC_OFS_MASK)   mask <= WDATA;
      if (ADDR == `TMCC_OFS_CMPA_L) cmpa_buf[7:0] <= WDATA;
      if (ADDR == `TMCC_OFS_CMPA_H) cmpa_buf[15:8] <= WDATA;
      if (ADDR == `TMCC_OFS_CMPB_L) cmpb_buf[7:0] <= WDATA;
      if (ADDR == `TMCC_OFS_CMPB_H) cmpb_buf[15:8] <= WDATA;
    end
  end

  // Counter, direction, compare reload and capture register.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      cnt           <= `TMCC_RST_WORD;
      up            <= 1'b1;
      cmpa          <= `TMCC_RST_WORD;
      cmpb          <= `TMCC_RST_WORD;
      capture_value <= `TMCC_RST_WORD;
    end
    else
    begin
      if (WR && ADDR == `TMCC_OFS_CNT_L)      cnt[7:0] <= WDATA;
      else if (WR && ADDR == `TMCC_OFS_CNT_H) cnt[15:8] <= WDATA;
      else if (tick)                          cnt <= next_cnt;
      if (!dual || turn_bot)                  up <= 1'b1;
      else if (turn_top)                      up <= 1'b0;
      if (reload)
      begin
        cmpa <= cmpa_buf;
        cmpb <= cmpb_buf;
      end
      if (cap_evt)                            capture_value <= cnt;
      else if (WR && ADDR == `TMCC_OFS_CAP_L) capture_value[7:0] <= WDATA;
      else if (WR && ADDR == `TMCC_OFS_CAP_H) capture_value[15:8] <= WDATA;
    end
  end

  // Prescaler, external clock synchroniser, flags and outputs.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      presc         <= `TMCC_RST_PRESC;
      ext_s1        <= 1'b0;
      ext_s2        <= 1'b0;
      ext_s3        <= 1'b0;
      status        <= `TMCC_RST_BYTE;
      IRQ           <= 1'b0;
      RDATA         <= `TMCC_RST_BYTE;
      COMPARE_A_OUT <= 1'b0;
      COMPARE_B_OUT <= 1'b0;
    end
    else
    begin
      presc         <= presc + 10'h001;
      ext_s1        <= EXT_CLK_PIN;
      ext_s2        <= ext_s1;
      ext_s3        <= ext_s2;
      status        <= next_status;
      IRQ           <= |(next_status & mask);
      RDATA         <= RD ? read_value : `TMCC_RST_BYTE;
      COMPARE_A_OUT <= oc_next(COMPARE_A_OUT, ctrl_a[`TMCC_A_COMA+1:`TMCC_A_COMA], kind,
                               tog_a, match_a, up, wrap);
      COMPARE_B_OUT <= oc_next(COMPARE_B_OUT, ctrl_a[`TMCC_A_COMB+1:`TMCC_A_COMB], kind,
                               1'b0, match_b, up, wrap);
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  mode_fixed_top_a: assert property (wave_mode == 4'h7 |-> top == `TMCC_TOP_10BIT)
    else $error("Fast 10-bit mode has the wrong TOP.");
  mode_join_a: assert property (WR && ADDR == `TMCC_OFS_CTRL_A && WDATA[1:0] == 2'h3
    |=> wave_mode[1:0] == 2'h3)
    else $error("Control A low bits do not reach the waveform mode.");
  ctc_clear_a: assert property (wave_mode == 4'h4 && tick && cnt == cmpa && !cnt_write
    |=> cnt == `TMCC_RST_WORD)
    else $error("Clear-on-match mode did not clear at compare A.");
  phase_reload_a: assert property (kind == TMCC_PHASE && turn_top
    |=> cmpa == $past(cmpa_buf))
    else $error("Phase correct mode did not reload compare A at TOP.");
  capture_copy_a: assert property (cap_evt |=> capture_value == $past(cnt) &&
    status[`TMCC_ST_CAP])
    else $error("Capture did not copy the counter and set the flag.");
  capture_off_a: assert property (cap_is_top |-> !cap_evt)
    else $error("Capture event while capture register is TOP.");
  clock_stop_a: assert property (cs == TMCC_CS_STOP && !cnt_write |=> $stable(cnt))
    else $error("Counter moved with no clock source.");
  div_eight_a: assert property (cs == TMCC_CS_DIV8 && tick |-> presc[2:0] == 3'h7)
    else $error("Divide-by-eight tick at the wrong prescaler phase.");
  ext_rise_a: assert property (cs == TMCC_CS_EXT_RISE && tick |-> ext_rise)
    else $error("External rising count without a rising edge.");
  dual_clear_a: assert property (dual && ctrl_a[7:6] == 2'h2 && match_a && up
    |=> !COMPARE_A_OUT)
    else $error("Compare A output not cleared on up-count match.");
  ctrl_bit5_a: assert property (WR && ADDR == `TMCC_OFS_CTRL_B |=> !ctrl_b[5])
    else $error("Unused control B bit became set.");

  cover property (cap_evt);
  cover property (kind == TMCC_FAST && ovf_evt);
  cover property (turn_top ##[1:300] turn_bot);
  cover property (IRQ);
endmodule
`default_nettype wire
